/* File: dpsm_host.sv */
// Host controller that drives one port of a dual-port semaphore/mailbox RAM
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_consts.svh"

module dpsm_host
   import dpsm_pkg::*;
#(
   parameter bit RIGHT_PORT = 1'b0
)(
   input  wire logic          mclk,
   input  wire logic          arst_n,
   input  wire logic          cmd_valid,
   output logic               cmd_ready,
   input  wire dpsm_cmd_t     cmd,
   output logic               rsp_valid,
   output dpsm_rsp_t          rsp,
   output logic               mail_pending,
   output dpsm_pins_t         pins,
   input  wire dpsm_pins_in_t pins_in
);

   // ----------------------------------------
   // Mailbox addresses for this side
   // ----------------------------------------
   localparam logic [`DPSM_AW-1:0] MBOX_OWN  =
      RIGHT_PORT ? `DPSM_MBOX_RIGHT : `DPSM_MBOX_LEFT;
   localparam logic [`DPSM_AW-1:0] MBOX_PEER =
      RIGHT_PORT ? `DPSM_MBOX_LEFT : `DPSM_MBOX_RIGHT;
   localparam logic [`DPSM_CNT_W-1:0] ACC_LAST =
      `DPSM_CNT_W'(`DPSM_ACC_CYC - 1);

   localparam dpsm_pins_t PINS_IDLE = '{
      chip_en_n : 1'b1,
      out_en_n  : 1'b1,
      rd_wr_n   : 1'b1,
      sem_en_n  : 1'b1,
      addr      : '0,
      dq_o      : '0,
      dq_oe_n   : 1'b1
   };

   dpsm_regs_t r_q;
   dpsm_regs_t r_d;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic                dec_sem;
   logic                dec_wr;
   logic [`DPSM_AW-1:0] dec_addr;
   logic [`DPSM_DW-1:0] dec_data;

   always_comb begin
      case (cmd.op)
         DPSM_OP_READ: begin
            dec_sem  = 1'b0;
            dec_wr   = 1'b0;
            dec_addr = cmd.addr;
            dec_data = cmd.data;
         end

         DPSM_OP_WRITE: begin
            dec_sem  = 1'b0;
            dec_wr   = 1'b1;
            dec_addr = cmd.addr;
            dec_data = cmd.data;
         end

         DPSM_OP_SEM_TAKE: begin
            dec_sem  = 1'b1;
            dec_wr   = 1'b1;
            dec_addr = {{(`DPSM_AW-`DPSM_SEM_IDX_W){1'b0}},
                        cmd.addr[`DPSM_SEM_IDX_W-1:0]};
            // Only bit zero reaches the latch; the other bits are kept quiet
            dec_data = {{(`DPSM_DW-1){1'b0}}, `DPSM_SEM_TAKE_VAL};
         end

         DPSM_OP_SEM_GIVE: begin
            dec_sem  = 1'b1;
            dec_wr   = 1'b1;
            dec_addr = {{(`DPSM_AW-`DPSM_SEM_IDX_W){1'b0}},
                        cmd.addr[`DPSM_SEM_IDX_W-1:0]};
            dec_data = {{(`DPSM_DW-1){1'b0}}, `DPSM_SEM_GIVE_VAL};
         end

         DPSM_OP_MAIL_POST: begin
            dec_sem  = 1'b0;
            dec_wr   = 1'b1;
            dec_addr = MBOX_PEER;
            dec_data = cmd.data;
         end

         DPSM_OP_MAIL_FETCH: begin
            dec_sem  = 1'b0;
            dec_wr   = 1'b0;
            dec_addr = MBOX_OWN;
            dec_data = cmd.data;
         end

         // Unused codes fall back to a plain read, which cannot disturb the far side
         default: begin
            dec_sem  = 1'b0;
            dec_wr   = 1'b0;
            dec_addr = cmd.addr;
            dec_data = cmd.data;
         end
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      r_d = r_q;
      r_d.rsp_valid = 1'b0;
      // Flag pin is active low; raised and cleared by the far device
      r_d.mail_pend = ~pins_in.mail_n;
      case (r_q.st)
         DPSM_IDLE: begin
            if (cmd_valid) begin
               r_d.cmd = cmd;
               r_d.cnt = '0;
               r_d.sem = dec_sem;
               r_d.wr  = dec_wr;
               r_d.pins.addr = dec_addr;
               r_d.pins.dq_o = dec_data;
               // Chip enable and semaphore enable are never low together
               r_d.pins.chip_en_n = dec_sem;
               r_d.pins.sem_en_n  = ~dec_sem;
               r_d.pins.rd_wr_n   = ~dec_wr;
               r_d.pins.out_en_n  = dec_wr;
               r_d.pins.dq_oe_n   = ~dec_wr;
               r_d.st = DPSM_ACT;
            end
         end

         DPSM_ACT: begin
            r_d.cnt = r_q.cnt + 1'b1;
            // Busy is only watched here and only for memory accesses; a collision restarts the access
            if (!pins_in.busy_n && !r_q.sem) begin
               r_d.cnt = '0;
            end else if (r_q.cnt == ACC_LAST) begin
               r_d.rdata = pins_in.dq_i;
               r_d.pins.chip_en_n = 1'b1;
               r_d.pins.sem_en_n  = 1'b1;
               r_d.pins.rd_wr_n   = 1'b1;
               r_d.pins.out_en_n  = 1'b1;
               r_d.st = DPSM_GAP;
            end
         end

         DPSM_GAP: begin
            // Data held one cycle past the strobe for write hold time
            r_d.pins.dq_oe_n = 1'b1;
            if (r_q.cmd.op == DPSM_OP_SEM_TAKE && r_q.wr) begin
               // Read back to learn whether the latch was granted
               r_d.wr = 1'b0;
               r_d.cnt = '0;
               r_d.pins.sem_en_n = 1'b0;
               r_d.pins.out_en_n = 1'b0;
               r_d.st = DPSM_ACT;
            end else begin
               r_d.rsp_valid = 1'b1;
               r_d.rsp.data  = r_q.wr ? r_q.cmd.data : r_q.rdata;
               r_d.rsp.ok    = (r_q.cmd.op == DPSM_OP_SEM_TAKE) ?
                               (r_q.rdata[0] == `DPSM_SEM_TAKE_VAL) : 1'b1;
               r_d.st = DPSM_IDLE;
            end
         end

         default: begin
            r_d.st   = DPSM_IDLE;
            r_d.pins = PINS_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         r_q.st        <= DPSM_IDLE;
         r_q.cnt       <= '0;
         r_q.cmd       <= '0;
         r_q.wr        <= 1'b0;
         r_q.sem       <= 1'b0;
         r_q.rdata     <= '0;
         r_q.pins      <= PINS_IDLE;
         r_q.rsp_valid <= 1'b0;
         r_q.rsp       <= '0;
         r_q.mail_pend <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign cmd_ready    = (r_q.st == DPSM_IDLE);
   assign rsp_valid    = r_q.rsp_valid;
   assign rsp          = r_q.rsp;
   assign mail_pending = r_q.mail_pend;
   assign pins         = r_q.pins;

endmodule
`default_nettype wire

/* File: dpsm_consts.svh */
// Constants for the dual-port semaphore and mailbox host controller
`ifndef DPSM_CONSTS_SVH
`define DPSM_CONSTS_SVH

// ----------------------------------------
// Address map of the far device
// ----------------------------------------
`define DPSM_AW            13
`define DPSM_DW            8
`define DPSM_MBOX_LEFT     13'h1FFE
`define DPSM_MBOX_RIGHT    13'h1FFF
`define DPSM_SEM_IDX_W     3
`define DPSM_SEM_TAKE_VAL  1'h0
`define DPSM_SEM_GIVE_VAL  1'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define DPSM_CLK_NS        20
`define DPSM_T_ACC_NS      55
`define DPSM_ACC_CYC       ((`DPSM_T_ACC_NS + `DPSM_CLK_NS - 1) / `DPSM_CLK_NS)
`define DPSM_CNT_W         3

`endif

/* File: dpsm_pkg.sv */
// Types for the dual-port semaphore and mailbox host controller
`include "dpsm_consts.svh"

package dpsm_pkg;

   // ----------------------------------------
   // User commands
   // ----------------------------------------
   typedef enum logic [2:0] {
      DPSM_OP_READ       = 3'h0,
      DPSM_OP_WRITE      = 3'h1,
      DPSM_OP_SEM_TAKE   = 3'h2,
      DPSM_OP_SEM_GIVE   = 3'h3,
      DPSM_OP_MAIL_POST  = 3'h4,
      DPSM_OP_MAIL_FETCH = 3'h5
   } dpsm_op_t;

   typedef struct packed {
      dpsm_op_t                 op;
      logic [`DPSM_AW-1:0]      addr;
      logic [`DPSM_DW-1:0]      data;
   } dpsm_cmd_t;

   typedef struct packed {
      logic                     ok;
      logic [`DPSM_DW-1:0]      data;
   } dpsm_rsp_t;

   // ----------------------------------------
   // Device port pins
   // ----------------------------------------
   typedef struct packed {
      logic                     chip_en_n;
      logic                     out_en_n;
      logic                     rd_wr_n;
      logic                     sem_en_n;
      logic [`DPSM_AW-1:0]      addr;
      logic [`DPSM_DW-1:0]      dq_o;
      logic                     dq_oe_n;
   } dpsm_pins_t;

   typedef struct packed {
      logic [`DPSM_DW-1:0]      dq_i;
      logic                     mail_n;
      logic                     busy_n;
   } dpsm_pins_in_t;

   typedef enum logic [2:0] {
      DPSM_IDLE = 3'b001,
      DPSM_ACT  = 3'b010,
      DPSM_GAP  = 3'b100
   } dpsm_state_t;

   typedef struct packed {
      dpsm_state_t              st;
      logic [`DPSM_CNT_W-1:0]   cnt;
      dpsm_cmd_t                cmd;
      logic                     wr;
      logic                     sem;
      logic [`DPSM_DW-1:0]      rdata;
      dpsm_pins_t               pins;
      logic                     rsp_valid;
      dpsm_rsp_t                rsp;
      logic                     mail_pend;
   } dpsm_regs_t;

endpackage

/* File: dpsm_host_props.sv */
// Checker for the semaphore and mailbox host port
`timescale 1ns/1ps
`default_nettype none
module dpsm_host_props
   import dpsm_pkg::*;
(
   input wire logic          mclk,
   input wire logic          arst_n,
   input wire logic          cmd_valid,
   input wire logic          cmd_ready,
   input wire dpsm_cmd_t     cmd,
   input wire logic          rsp_valid,
   input wire dpsm_rsp_t     rsp,
   input wire logic          mail_pending,
   input wire dpsm_pins_t    pins,
   input wire dpsm_pins_in_t pins_in
);
   logic tk;
   assign tk = cmd_valid && cmd_ready;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   AST_SEM_SEL: assert property (tk && cmd.op inside {DPSM_OP_SEM_TAKE, DPSM_OP_SEM_GIVE}
      |=> !pins.sem_en_n && pins.chip_en_n) else $error("sem strobe");
   AST_SEM_IDX: assert property (tk && cmd.op == DPSM_OP_SEM_GIVE
      |=> pins.addr[2:0] == $past(cmd.addr[2:0])) else $error("sem index");
   AST_SEM_TAKE: assert property (tk && cmd.op == DPSM_OP_SEM_TAKE
      |=> !pins.dq_oe_n && !pins.rd_wr_n && pins.dq_o == 8'h00) else $error("take");
   AST_SEM_GIVE: assert property (tk && cmd.op == DPSM_OP_SEM_GIVE
      |=> pins.dq_o == 8'h01) else $error("give value");
   AST_POST: assert property (tk && cmd.op == DPSM_OP_MAIL_POST
      |=> pins.addr == 13'h1FFF && !pins.rd_wr_n) else $error("post");
   AST_FETCH: assert property (tk && cmd.op == DPSM_OP_MAIL_FETCH
      |=> pins.addr == 13'h1FFE && !pins.out_en_n) else $error("fetch");
   AST_MAIL: assert property ($fell(pins_in.mail_n) |=> mail_pending) else $error("mail");
   AST_RSP: assert property ((tk && cmd.op == DPSM_OP_WRITE) ##1 pins_in.busy_n [*4]
      |=> rsp_valid) else $error("late write");
endmodule
bind dpsm_host dpsm_host_props i_props (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
   .mail_pending(mail_pending), .pins(pins), .pins_in(pins_in));
`default_nettype wire

/* File: dpsm_dev.sv */
// Far device model: memory, eight semaphores, two mailbox flags
`timescale 1ns/1ps
`default_nettype none
module dpsm_dev
   import dpsm_pkg::*;
(
   input  wire logic        mclk,
   input  wire dpsm_pins_t  pins,
   output dpsm_pins_in_t    pins_in,
   input  wire logic        busy_n,
   input  wire logic        r_we,
   input  wire logic        r_rd,
   input  wire logic [12:0] r_addr,
   input  wire logic        r_sem,
   output logic             int_r_n
);
   logic [7:0] mem [0:8191];
   logic [7:0] ol = 0, orr = 0, ql = 0, qr = 0, last = 0, dq;
   logic       int_l_n = 1, int_r_q = 1, sel, rd;
   assign int_r_n = int_r_q;
   assign sel = !pins.chip_en_n || !pins.sem_en_n;
   assign rd = sel && pins.rd_wr_n && !pins.out_en_n;
   // Released bus shows the inverse so a stale byte cannot pass
   assign dq = !rd ? ~last : !pins.sem_en_n ? {8{!ol[pins.addr[2:0]]}} : mem[pins.addr];
   assign pins_in = {dq, int_l_n, busy_n};
   task automatic semw(input bit rt, input int i, input bit v);
      if (rt) qr[i] = !v; else ql[i] = !v;
      if (!ql[i]) ol[i] = 0;
      if (!qr[i]) orr[i] = 0;
      if (!orr[i] && ql[i]) ol[i] = 1;
      if (!ol[i] && qr[i]) orr[i] = 1;
   endtask
   always @(posedge mclk) begin
      if (rd) last <= dq;
      if (r_we && r_sem) semw(1, r_addr[2:0], r_addr[12]);
      if (r_we && !r_sem && r_addr == 13'h1FFE) int_l_n <= 0;
      if (r_rd && r_addr == 13'h1FFF) int_r_q <= 1;
      if (rd && pins.sem_en_n && pins.addr == 13'h1FFE) int_l_n <= 1;
      if (sel && !pins.rd_wr_n && !pins.dq_oe_n) begin
         if (!pins.sem_en_n) semw(0, pins.addr[2:0], pins.dq_o[0]);
         else mem[pins.addr] <= pins.dq_o;
         if (pins.sem_en_n && pins.addr == 13'h1FFF) int_r_q <= 0;
      end
   end
endmodule
`default_nettype wire

/* File: dpsm_host_tb.sv */
// Testbench for the semaphore and mailbox host port
`timescale 1ns/1ps
`default_nettype none
module dpsm_host_tb;
   import dpsm_pkg::*;
   logic          mclk = 0, arst_n = 0, cmd_valid = 0, busy_n = 1, r_we = 0, r_rd = 0;
   logic          r_sem = 0, cmd_ready, rsp_valid, mail_pending, int_r_n;
   logic [12:0]   r_addr = 0, a;
   logic [7:0]    d, em [int];
   dpsm_cmd_t     cmd = '0;
   dpsm_rsp_t     rsp;
   dpsm_pins_t    pins;
   dpsm_pins_in_t pins_in;
   int            errors = 0, check_count = 0, seed = 32'h6E7E;
   always #10 mclk = ~mclk;
   dpsm_host #(.RIGHT_PORT(1'b0)) i_dpsm_host (.mclk(mclk), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
      .rsp(rsp), .mail_pending(mail_pending), .pins(pins), .pins_in(pins_in));
   dpsm_dev i_dpsm_dev (.mclk(mclk), .pins(pins), .pins_in(pins_in), .busy_n(busy_n),
      .r_we(r_we), .r_rd(r_rd), .r_addr(r_addr), .r_sem(r_sem), .int_r_n(int_r_n));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Mask hides fields that a command does not define
   task automatic op(input dpsm_op_t o, input int ad, input logic [7:0] dd,
                     input logic [8:0] e, input logic [8:0] m);
      @(negedge mclk);
      cmd_valid = 1;
      cmd = '{o, 13'(ad), dd};
      while (!cmd_ready) @(negedge mclk);
      @(negedge mclk);
      cmd_valid = 0;
      for (int n = 0; n < 99 && !rsp_valid; n++) @(negedge mclk);
      // A response that never comes counts as a mismatch
      chk({8'h00, rsp_valid}, 9'h001);
      chk(rsp & m, e & m);
   endtask
   task automatic rt(input bit we, input bit rd, input bit sm, input logic [12:0] ad);
      @(negedge mclk);
      {r_we, r_rd, r_sem, r_addr} = {we, rd, sm, ad};
      @(negedge mclk);
      {r_we, r_rd} = 2'h0;
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100us;
      errors++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge mclk);
      @(negedge mclk) arst_n = 1;
      for (int i = 0; i < 6; i++) begin
         a = 13'($random(seed) & 32'hFFF);
         d = 8'($random(seed));
         em[a] = d;
         fork
            op(DPSM_OP_WRITE, a, d, {1'b1, d}, 9'h1FF);
            if (i == 3) begin
               repeat (2) @(negedge mclk);
               busy_n = 0;
               repeat (3) @(negedge mclk);
               busy_n = 1;
            end
         join
         op(DPSM_OP_READ, a, 8'h00, {1'b1, em[a]}, 9'h1FF);
      end
      $display("memory test done");
      for (int i = 0; i < 8; i++) op(DPSM_OP_SEM_TAKE, i, 0, 9'h100, 9'h100);
      rt(1, 0, 1, 13'h0005);
      op(DPSM_OP_SEM_GIVE, 5, 0, 9'h100, 9'h100);
      op(DPSM_OP_SEM_TAKE, 5, 0, 9'h000, 9'h100);
      op(DPSM_OP_SEM_GIVE, 5, 0, 9'h100, 9'h100);
      rt(1, 0, 1, 13'h1005);
      op(DPSM_OP_SEM_TAKE, 13'h1FFD, 0, 9'h100, 9'h100);
      $display("semaphore test done");
      rt(1, 0, 0, 13'h1FFE);
      // The host mirrors the flag pin one cycle after it falls
      @(negedge mclk);
      chk({8'h00, mail_pending}, 9'h001);
      op(DPSM_OP_MAIL_FETCH, 0, 0, 9'h100, 9'h100);
      chk({8'h00, mail_pending}, 9'h000);
      op(DPSM_OP_MAIL_POST, 0, 8'hA5, 9'h1A5, 9'h1FF);
      chk({8'h00, int_r_n}, 9'h000);
      rt(0, 1, 0, 13'h1FFF);
      chk({8'h00, int_r_n}, 9'h001);
      $display("mailbox test done");
      end_of_test;
   end
endmodule
`default_nettype wire
